// *** rtl/dtc_top.sv ***
// dual counter/timer control: control, mode, prescale and count
// registers of timer 0 and timer 1 plus the two external interrupt
// flags that share the control register.
// assumes one special-function-register bus master and synchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_cfg.svh"

module dtc_top #(
	parameter int DIV = `DTC_PRESCALE_DIV  // clocks per prescaled tick
) (
	// clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_arst_n,
	// special-function-register bus
	input  wire dtc_pkg::dtc_sfr_req_type   i_sfr,
	output logic [7:0]                      o_sfr_rdata,
	// pins from port logic
	input  wire dtc_pkg::dtc_pins_type      i_pins,
	// interrupt vectoring acknowledges, one cycle each
	input  wire dtc_pkg::dtc_irq_flags_type i_vector_ack,
	// flags toward the interrupt controller
	output dtc_pkg::dtc_irq_flags_type      o_irq_flags,
	// timer1 overflow pulse for baud generation, and timer2 prescale
	output logic                            o_timer1_overflow,
	output logic                            o_timer2_prescale_bypass
);

	// the divider cannot make a tick period shorter than two clocks
	if (DIV < 2 || DIV > 255) begin : g_bad_div
		$error("dtc_top: DIV must lie in 2..255");
	end

	localparam int DW = $clog2(DIV);

	// address match, used by every write decode; the read mux compares addresses directly
	function automatic logic addr_hit(input logic [7:0] a,
	                                  input logic [7:0] off);
		return a == off;
	endfunction

	// one counting step for modes 13-bit, 16-bit and reload8
	function automatic logic [16:0] count_step(
		input dtc_pkg::dtc_mode_type m,
		input logic [7:0] lo,
		input logic [7:0] hi,
		input logic       inc);
		logic [7:0] nlo;
		logic [7:0] nhi;
		logic       ovf;
		nlo = lo;
		nhi = hi;
		ovf = 1'b0;
		if (inc) begin
			case (m)
				dtc_pkg::DTC_MODE_13BIT: begin
					// upper three low-byte bits are left alone
					nlo[4:0] = lo[4:0] + 5'h01;
					if (lo[4:0] == 5'h1F) begin
						nhi = hi + 8'h01;
						ovf = (hi == 8'hFF);
					end
				end
				dtc_pkg::DTC_MODE_16BIT: begin
					nlo = lo + 8'h01;
					if (lo == 8'hFF) begin
						nhi = hi + 8'h01;
						ovf = (hi == 8'hFF);
					end
				end
				dtc_pkg::DTC_MODE_RELOAD8: begin
					// high byte only supplies the reload value
					if (lo == 8'hFF) begin
						nlo = hi;
						ovf = 1'b1;
					end else begin
						nlo = lo + 8'h01;
					end
				end
				default: begin
					// split handled by the caller; stopped just keeps the count
				end
			endcase
		end
		return {ovf, nhi, nlo};
	endfunction

	// control register bits
	logic tf1, tr1, tf0, tr0, ie1, it1, ie0, it0;
	logic [7:0] timer_mode;              // timer_mode
	logic [2:0] timer_prescale_select;             // timer_prescale_select bits 5..3
	logic [7:0] tl0, th0, tl1, th1;
	logic [DW-1:0] div_cnt;        // prescale divider
	logic div_tick;                // one pulse per DIV clocks
	logic irq0_prev, irq1_prev;    // last interrupt pin levels

	// decoded fields
	dtc_pkg::dtc_mode_type mode0, mode1;
	logic timer0_pin_gating, timer1_pin_gating, csel0, csel1, t0m, t1m;
	assign mode0 = dtc_pkg::dtc_mode_type'(
		timer_mode[`DTC_LSB_TIMER0_MODE_FIELD +: 2]);
	assign mode1 = dtc_pkg::dtc_mode_type'(
		timer_mode[`DTC_LSB_TIMER1_MODE_FIELD +: 2]);
	assign timer0_pin_gating = timer_mode[`DTC_BIT_TIMER0_PIN_GATING];
	assign timer1_pin_gating = timer_mode[`DTC_BIT_TIMER1_PIN_GATING];
	assign csel0 = timer_mode[`DTC_BIT_TIMER0_COUNTER_SEL];
	// timer1 loses its event input while timer0 is split
	assign csel1 = timer_mode[`DTC_BIT_TIMER1_COUNTER_SEL]
	               & (mode0 != dtc_pkg::DTC_MODE_SPLIT);
	assign t0m = timer_prescale_select[`DTC_BIT_TIMER0_PRESCALE_BYP - 3];
	assign t1m = timer_prescale_select[`DTC_BIT_TIMER1_PRESCALE_BYP - 3];

	// write strobes
	logic wr_timer_control, wr_timer_mode, wr_timer_prescale_select, wr_tl0, wr_th0, wr_tl1, wr_th1;
	assign wr_timer_control  = i_sfr.wr & addr_hit(i_sfr.addr,
	                                      `DTC_ADDR_TIMER_CONTROL);
	assign wr_timer_mode  = i_sfr.wr & addr_hit(i_sfr.addr, `DTC_ADDR_TIMER_MODE);
	assign wr_timer_prescale_select = i_sfr.wr & addr_hit(i_sfr.addr,
	                                      `DTC_ADDR_TIMER_PRESCALE_SEL);
	assign wr_tl0 = i_sfr.wr & addr_hit(i_sfr.addr,
	                                    `DTC_ADDR_TIMER0_COUNT_LOW);
	assign wr_th0 = i_sfr.wr & addr_hit(i_sfr.addr,
	                                    `DTC_ADDR_TIMER0_COUNT_HIGH);
	assign wr_tl1 = i_sfr.wr & addr_hit(i_sfr.addr,
	                                    `DTC_ADDR_TIMER1_COUNT_LOW);
	assign wr_th1 = i_sfr.wr & addr_hit(i_sfr.addr,
	                                    `DTC_ADDR_TIMER1_COUNT_HIGH);

	// prescale divider: a free-running enable, never a second clock
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_cnt <= '0;
		end else if (div_tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + DW'(1);
		end
	end
	assign div_tick = (div_cnt == DW'(DIV - 1));

	// tick sources for both timers
	logic [1:0] tick;
	logic [1:0] tsel, tbyp, tpin;
	assign tsel = {csel1, csel0};
	assign tbyp = {t1m, t0m};
	assign tpin = {i_pins.timer1_event_pin, i_pins.timer0_event_pin};
	for (genvar g = 0; g < 2; g++) begin : g_tick
		dtc_tick_sel u_tick (
			.i_ref_clk         (i_ref_clk),
			.i_arst_n          (i_arst_n),
			.i_counter_select  (tsel[g]),
			.i_prescale_bypass (tbyp[g]),
			.i_div_tick        (div_tick),
			.i_event_pin       (tpin[g]),
			.o_tick            (tick[g])
		);
	end

	// run and gating; split high byte runs off timer1's run bit
	logic inc0, inc1, inc0h;
	assign inc0 = tr0 & (~timer0_pin_gating | i_pins.ext_irq0_pin_n) & tick[0];
	assign inc1 = tr1 & (~timer1_pin_gating | i_pins.ext_irq1_pin_n) & tick[1];
	assign inc0h = tr1 & (t0m | div_tick);

	// next counts and overflow events
	logic [7:0] next_tl0, next_th0, next_tl1, next_th1;
	logic ovf0, ovf1, ovf0h;
	always_comb begin
		logic [16:0] s0;
		logic [16:0] s1;
		logic [8:0]  lo_sum;
		logic [8:0]  hi_sum;
		s0 = count_step(mode0, tl0, th0, inc0);
		s1 = count_step(mode1, tl1, th1, inc1);
		lo_sum = {1'b0, tl0} + 9'h001;
		hi_sum = {1'b0, th0} + 9'h001;
		{ovf0, next_th0, next_tl0} = s0;
		ovf0h = 1'b0;
		if (mode0 == dtc_pkg::DTC_MODE_SPLIT) begin
			// two independent 8-bit counters
			next_tl0 = inc0 ? lo_sum[7:0] : tl0;
			ovf0 = inc0 & lo_sum[8];
			next_th0 = inc0h ? hi_sum[7:0] : th0;
			ovf0h = inc0h & hi_sum[8];
		end
		{ovf1, next_th1, next_tl1} = s1;  // stopped mode keeps count
	end

	// timer1 flag source swaps while timer0 is split
	logic set_tf0, set_tf1;
	assign set_tf0 = ovf0;
	assign set_tf1 = (mode0 == dtc_pkg::DTC_MODE_SPLIT) ? ovf0h : ovf1;

	// timer0 count bytes: software write wins over counting
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tl0 <= `DTC_RST_COUNT;
			th0 <= `DTC_RST_COUNT;
		end else begin
			tl0 <= wr_tl0 ? i_sfr.wdata : next_tl0;
			th0 <= wr_th0 ? i_sfr.wdata : next_th0;
		end
	end

	// timer1 count bytes
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tl1 <= `DTC_RST_COUNT;
			th1 <= `DTC_RST_COUNT;
		end else begin
			tl1 <= wr_tl1 ? i_sfr.wdata : next_tl1;
			th1 <= wr_th1 ? i_sfr.wdata : next_th1;
		end
	end

	// overflow flags: a hardware set beats a same-cycle clear
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tf0 <= 1'b0;
			tf1 <= 1'b0;
		end else begin
			if (set_tf0) begin
				tf0 <= 1'b1;
			end else if (wr_timer_control) begin
				tf0 <= i_sfr.wdata[`DTC_BIT_TIMER0_OVERFLOW_FLAG];
			end else if (i_vector_ack.timer0_overflow_flag) begin
				tf0 <= 1'b0;
			end
			if (set_tf1) begin
				tf1 <= 1'b1;
			end else if (wr_timer_control) begin
				tf1 <= i_sfr.wdata[`DTC_BIT_TIMER1_OVERFLOW_FLAG];
			end else if (i_vector_ack.timer1_overflow_flag) begin
				tf1 <= 1'b0;
			end
		end
	end

	// run and type bits
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			{tr1, tr0, it1, it0} <= 4'h0;
		end else if (wr_timer_control) begin
			tr1 <= i_sfr.wdata[`DTC_BIT_TIMER1_RUN];
			tr0 <= i_sfr.wdata[`DTC_BIT_TIMER0_RUN];
			it1 <= i_sfr.wdata[`DTC_BIT_EXT_IRQ1_TYPE];
			it0 <= i_sfr.wdata[`DTC_BIT_EXT_IRQ0_TYPE];
		end
	end

	// interrupt pin history for falling-edge detection
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq0_prev <= 1'b1;
			irq1_prev <= 1'b1;
		end else begin
			irq0_prev <= i_pins.ext_irq0_pin_n;
			irq1_prev <= i_pins.ext_irq1_pin_n;
		end
	end

	logic fall0, fall1;
	assign fall0 = irq0_prev & ~i_pins.ext_irq0_pin_n;
	assign fall1 = irq1_prev & ~i_pins.ext_irq1_pin_n;

	// external flags; level mode tracks the pin one clock late
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ie0 <= 1'b0;
			ie1 <= 1'b0;
		end else begin
			if (!it1) begin
				ie1 <= ~i_pins.ext_irq1_pin_n;
			end else if (fall1) begin
				ie1 <= 1'b1;
			end else if (wr_timer_control) begin
				ie1 <= i_sfr.wdata[`DTC_BIT_EXT_IRQ1_FLAG];
			end else if (i_vector_ack.ext_irq1_flag) begin
				ie1 <= 1'b0;
			end
			if (!it0) begin
				ie0 <= ~i_pins.ext_irq0_pin_n;
			end else if (fall0) begin
				ie0 <= 1'b1;
			end else if (wr_timer_control) begin
				ie0 <= i_sfr.wdata[`DTC_BIT_EXT_IRQ0_FLAG];
			end else if (i_vector_ack.ext_irq0_flag) begin
				ie0 <= 1'b0;
			end
		end
	end

	// mode and prescale registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer_mode  <= `DTC_RST_TIMER_MODE;
			timer_prescale_select <= `DTC_RST_PRESCALE_SEL;
		end else begin
			if (wr_timer_mode) begin
				timer_mode <= i_sfr.wdata;
			end
			if (wr_timer_prescale_select) begin
				// only bits 5..3 are stored; the rest are dropped
				timer_prescale_select <= i_sfr.wdata[5:3];
			end
		end
	end

	// read data, registered; unmapped addresses return zero
	logic [7:0] timer_control_rd;
	assign timer_control_rd = {tf1, tr1, tf0, tr0, ie1, it1, ie0, it0};
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr.rd) begin
			case (i_sfr.addr)
				`DTC_ADDR_TIMER_CONTROL:      o_sfr_rdata <= timer_control_rd;
				`DTC_ADDR_TIMER_MODE:         o_sfr_rdata <= timer_mode;
				`DTC_ADDR_TIMER0_COUNT_LOW:   o_sfr_rdata <= tl0;
				`DTC_ADDR_TIMER1_COUNT_LOW:   o_sfr_rdata <= tl1;
				`DTC_ADDR_TIMER0_COUNT_HIGH:  o_sfr_rdata <= th0;
				`DTC_ADDR_TIMER1_COUNT_HIGH:  o_sfr_rdata <= th1;
				`DTC_ADDR_TIMER_PRESCALE_SEL:
					o_sfr_rdata <= {2'h0, timer_prescale_select, 3'h0};
				default:                      o_sfr_rdata <= 8'h00;
			endcase
		end
	end

	// timer1 overflow pulse survives split mode for baud use
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_timer1_overflow <= 1'b0;
		end else begin
			o_timer1_overflow <= ovf1;
		end
	end

	// timer2 only consumes this bit; its own modes decide relevance
	assign o_timer2_prescale_bypass =
		timer_prescale_select[`DTC_BIT_TIMER2_PRESCALE_BYP - 3];
	assign o_irq_flags = '{timer1_overflow_flag: tf1,
	                       timer0_overflow_flag: tf0,
	                       ext_irq1_flag: ie1,
	                       ext_irq0_flag: ie0};

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_t0_full16;
		mode0 == dtc_pkg::DTC_MODE_16BIT && inc0 && tl0 == 8'hFF
		&& th0 == 8'hFF && !wr_tl0 && !wr_th0;
	endsequence
	sequence s_t0_full13;
		mode0 == dtc_pkg::DTC_MODE_13BIT && inc0 && tl0[4:0] == 5'h1F
		&& th0 == 8'hFF && !wr_tl0 && !wr_th0;
	endsequence

	property p_t0_wrap16;
		s_t0_full16 |=> tl0 == 8'h00 && th0 == 8'h00 && tf0;
	endproperty
	a_t0_wrap16: assert property (p_t0_wrap16)
		else $error("16-bit wrap did not clear count and set flag");
	property p_t0_wrap13;
		s_t0_full13 |=> tl0[4:0] == 5'h00 && th0 == 8'h00 && tf0;
	endproperty
	a_t0_wrap13: assert property (p_t0_wrap13)
		else $error("13-bit wrap did not clear count and set flag");
	property p_t0_reload;
		mode0 == dtc_pkg::DTC_MODE_RELOAD8 && inc0 && tl0 == 8'hFF
		&& !wr_tl0 && !wr_th0 |=> tl0 == $past(th0) && th0 == $past(th0);
	endproperty
	a_t0_reload: assert property (p_t0_reload)
		else $error("reload mode did not reload from high byte");
	property p_t0_hold;
		!tr0 && !wr_tl0 && !wr_th0 && mode0 != dtc_pkg::DTC_MODE_SPLIT
		|=> $stable(tl0) && $stable(th0);
	endproperty
	a_t0_hold: assert property (p_t0_hold)
		else $error("stopped timer0 count moved");
	property p_t1_gate;
		timer1_pin_gating && !i_pins.ext_irq1_pin_n && !wr_tl1 && !wr_th1
		|=> $stable(tl1) && $stable(th1);
	endproperty
	a_t1_gate: assert property (p_t1_gate)
		else $error("gated timer1 counted with pin low");
	property p_tf1_vector_clear;
		tf1 && i_vector_ack.timer1_overflow_flag && !set_tf1 && !wr_timer_control
		|=> !tf1;
	endproperty
	a_tf1_vector_clear: assert property (p_tf1_vector_clear)
		else $error("timer1 flag not cleared on vectoring");
	property p_ie1_level;
		!it1 && !wr_timer_control |=> ie1 == !$past(i_pins.ext_irq1_pin_n);
	endproperty
	a_ie1_level: assert property (p_ie1_level)
		else $error("level-mode irq1 flag does not follow pin");
	property p_ie0_edge;
		it0 && irq0_prev && !i_pins.ext_irq0_pin_n |=> ie0;
	endproperty
	a_ie0_edge: assert property (p_ie0_edge)
		else $error("falling edge on irq0 not latched");
	property p_timer_prescale_select_top;
		i_sfr.rd && i_sfr.addr == `DTC_ADDR_TIMER_PRESCALE_SEL
		|=> o_sfr_rdata[7:6] == 2'h0 && o_sfr_rdata[2:0] == 3'h0;
	endproperty
	a_timer_prescale_select_top: assert property (p_timer_prescale_select_top)
		else $error("prescale register unused bits not zero");
	property p_div_period;
		div_tick |=> !div_tick [*8] ##1 !div_tick [*3] ##1 div_tick;
	endproperty
	a_div_period: assert property (p_div_period)
		else $error("prescale tick not every twelve clocks");
	property p_split_tf1;
		mode0 == dtc_pkg::DTC_MODE_SPLIT && ovf1 && !ovf0h && !wr_timer_control
		&& !tf1 |=> !tf1;
	endproperty
	a_split_tf1: assert property (p_split_tf1)
		else $error("timer1 set its flag while timer0 split");

endmodule

`default_nettype wire

// *** shared/dtc_cfg.svh ***
// constants for the dual timer control block: register offsets, field
// positions, reset values and the prescale count.
// assumes an 8-bit special-function-register address space.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// register offsets on the special-function-register bus
`define DTC_ADDR_TIMER_CONTROL        8'h88
`define DTC_ADDR_TIMER_MODE           8'h89
`define DTC_ADDR_TIMER0_COUNT_LOW     8'h8A
`define DTC_ADDR_TIMER1_COUNT_LOW     8'h8B
`define DTC_ADDR_TIMER0_COUNT_HIGH    8'h8C
`define DTC_ADDR_TIMER1_COUNT_HIGH    8'h8D
`define DTC_ADDR_TIMER_PRESCALE_SEL   8'h8E

// timer_control bit positions
`define DTC_BIT_TIMER1_OVERFLOW_FLAG  7
`define DTC_BIT_TIMER1_RUN            6
`define DTC_BIT_TIMER0_OVERFLOW_FLAG  5
`define DTC_BIT_TIMER0_RUN            4
`define DTC_BIT_EXT_IRQ1_FLAG         3
`define DTC_BIT_EXT_IRQ1_TYPE         2
`define DTC_BIT_EXT_IRQ0_FLAG         1
`define DTC_BIT_EXT_IRQ0_TYPE         0

// timer_mode bit positions
`define DTC_BIT_TIMER1_PIN_GATING     7
`define DTC_BIT_TIMER1_COUNTER_SEL    6
`define DTC_LSB_TIMER1_MODE_FIELD     4
`define DTC_BIT_TIMER0_PIN_GATING     3
`define DTC_BIT_TIMER0_COUNTER_SEL    2
`define DTC_LSB_TIMER0_MODE_FIELD     0

// timer_prescale_select bit positions
`define DTC_BIT_TIMER2_PRESCALE_BYP   5
`define DTC_BIT_TIMER1_PRESCALE_BYP   4
`define DTC_BIT_TIMER0_PRESCALE_BYP   3

// reset values
`define DTC_RST_TIMER_CONTROL         8'h00
`define DTC_RST_TIMER_MODE            8'h00
`define DTC_RST_COUNT                 8'h00
`define DTC_RST_PRESCALE_SEL          3'h0

// system clocks per prescaled tick
`define DTC_PRESCALE_DIV              12

`endif

// *** shared/dtc_pkg.sv ***
// types shared by the dual timer control block and its bench.
// assumes the constants header supplies all numeric values.
package dtc_pkg;

	// one request on the special-function-register bus
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dtc_sfr_req_type;

	// pins from port logic, taken as synchronous to the clock
	typedef struct packed {
		logic ext_irq1_pin_n;
		logic ext_irq0_pin_n;
		logic timer1_event_pin;
		logic timer0_event_pin;
	} dtc_pins_type;

	// the four interrupt flags, or the four vector acknowledges
	typedef struct packed {
		logic timer1_overflow_flag;
		logic timer0_overflow_flag;
		logic ext_irq1_flag;
		logic ext_irq0_flag;
	} dtc_irq_flags_type;

	// mode field decode, in field-code order
	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD8,
		DTC_MODE_SPLIT
	} dtc_mode_type;

endpackage

// *** rtl/dtc_tick_sel.sv ***
// per-timer count-enable source: prescaled clock tick or falling edge
// of the external event pin.
// assumes the event pin is synchronous to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none

module dtc_tick_sel (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_arst_n,
	// selection
	input  wire logic i_counter_select,   // 1: count event pin edges
	input  wire logic i_prescale_bypass,  // 1: every clock is a tick
	input  wire logic i_div_tick,         // one pulse per prescale period
	// event pin
	input  wire logic i_event_pin,
	// count enable, one cycle wide
	output logic      o_tick
);

	logic event_prev;  // last sampled event pin level

	// remember the pin so a high-to-low step can be seen
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			event_prev <= 1'b1;  // no false edge out of reset
		end else begin
			event_prev <= i_event_pin;
		end
	end

	// edges keep being tracked while stopped, so none is replayed later
	assign o_tick = i_counter_select ? (event_prev & ~i_event_pin)
	                                 : (i_prescale_bypass | i_div_tick);

endmodule

`default_nettype wire

// *** bench/dtc_cpu_model.sv ***
// cpu core model: register cycles and vector acknowledges on the bus.
// assumes the bench calls its tasks from the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_cfg.svh"

module dtc_cpu_model (
	// clock
	input  wire logic                     i_ref_clk,
	// requests toward the block
	output var dtc_pkg::dtc_sfr_req_type   o_sfr,
	output var dtc_pkg::dtc_irq_flags_type o_ack,
	// read data back
	input  wire logic [7:0]               i_rdata
);
	// bus idle at time zero
	initial begin
		o_sfr = '0;
		o_ack = '0;
	end

	// one write; data is scrambled once released so nothing relies on it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_sfr.addr = a;
		o_sfr.wdata = (a == `DTC_ADDR_TIMER_PRESCALE_SEL) ?
			(d & 8'hF8) : d;
		o_sfr.wr = 1'b1;
		@(negedge i_ref_clk);
		o_sfr.wr = 1'b0;
		o_sfr.wdata = ~o_sfr.wdata;
	endtask

	// one read; data is taken a cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		o_sfr.addr = a;
		o_sfr.rd = 1'b1;
		@(negedge i_ref_clk);
		o_sfr.rd = 1'b0;
		d = i_rdata;
	endtask

	// vectoring acknowledge, one cycle wide
	task automatic vec(input dtc_pkg::dtc_irq_flags_type f);
		@(negedge i_ref_clk);
		o_ack = f;
		@(negedge i_ref_clk);
		o_ack = '0;
	endtask
endmodule
`default_nettype wire

// *** bench/dtc_top_bench.sv ***
// bench for the dual timer block: register table, counting modes,
// gating, event counting and interrupt flags.
// assumes the cpu model owns the bus; pins change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module dtc_top_bench;
	logic                       ref_clk = 1'b0; // 20 MHz clock
	logic                       arst_n = 1'b0;  // reset, active low
	dtc_pkg::dtc_sfr_req_type   sfr;            // bus from the model
	dtc_pkg::dtc_pins_type      pins = 4'hF;    // pins idle high
	dtc_pkg::dtc_irq_flags_type ack;            // vector acknowledges
	dtc_pkg::dtc_irq_flags_type flags;          // flags out
	logic [7:0]                 rdata;          // read data
	logic                       ovf1;           // timer1 overflow pulse
	logic                       byp2;           // timer2 prescale bit
	logic [7:0]                 rd_v;           // last value read
	int                         failures = 0;   // mismatches
	int                         num_checks = 0; // comparisons
	// address, value written, value expected back
	logic [7:0] rows [8][3] = '{'{8'h89, 8'hA5, 8'hA5},
		'{8'h8A, 8'h3C, 8'h3C}, '{8'h8B, 8'h5A, 8'h5A},
		'{8'h8C, 8'hC3, 8'hC3}, '{8'h8D, 8'hA5, 8'hA5},
		'{8'h8E, 8'hFF, 8'h38}, '{8'h8F, 8'hFF, 8'h00},
		'{8'h88, 8'h05, 8'h05}};

	dtc_top u_dtc_top (
		.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_sfr(sfr),
		.o_sfr_rdata(rdata), .i_pins(pins), .i_vector_ack(ack),
		.o_irq_flags(flags), .o_timer1_overflow(ovf1),
		.o_timer2_prescale_bypass(byp2));

	dtc_cpu_model u_dtc_cpu_model (
		.i_ref_clk(ref_clk), .o_sfr(sfr), .o_ack(ack), .i_rdata(rdata));

	// free-running clock, 50 ns period
	always #25 ref_clk = ~ref_clk;

	// compare and count
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read a register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_dtc_cpu_model.rd(a, rd_v);
		chk("register", e, rd_v);
	endtask

	// falling edges on the timer0 event pin, each level two clocks
	task automatic ev0(input int n);
		repeat (n) begin
			repeat (2) @(negedge ref_clk);
			pins.timer0_event_pin = 1'b0;
			repeat (2) @(negedge ref_clk);
			pins.timer0_event_pin = 1'b1;
		end
	endtask

	// counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(negedge ref_clk);
		arst_n = 1'b1;
		// every register starts at zero, unmapped ones too
		for (int a = 8'h88; a <= 8'h8F; a++) rchk(8'(a), 8'h00);
		foreach (rows[i]) begin
			u_dtc_cpu_model.wr(rows[i][0], rows[i][1]);
			rchk(rows[i][0], rows[i][2]);
		end
		chk("t2 bypass", 8'h01, {7'h00, byp2});
		// 16-bit wrap one clock after run, then ack, then stop
		u_dtc_cpu_model.wr(8'h89, 8'h01);
		u_dtc_cpu_model.wr(8'h8E, 8'h08);
		u_dtc_cpu_model.wr(8'h8A, 8'hFF);
		u_dtc_cpu_model.wr(8'h8C, 8'hFF);
		u_dtc_cpu_model.wr(8'h88, 8'h10);
		@(negedge ref_clk);
		chk("t0 flag", 8'h01, {7'h00, flags.timer0_overflow_flag});
		u_dtc_cpu_model.vec(4'h4);
		chk("t0 ack", 8'h00, {7'h00, flags.timer0_overflow_flag});
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		rchk(8'h8A, 8'h04);
		rchk(8'h8C, 8'h00);
		// event counting, gated off while the irq0 pin is low
		u_dtc_cpu_model.wr(8'h89, 8'h0D);
		u_dtc_cpu_model.wr(8'h8A, 8'h00);
		u_dtc_cpu_model.wr(8'h88, 8'h10);
		ev0(3);
		pins.ext_irq0_pin_n = 1'b0;
		ev0(2);
		chk("irq0 level", 8'h01, {7'h00, flags.ext_irq0_flag});
		pins.ext_irq0_pin_n = 1'b1;
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		rchk(8'h8A, 8'h03);
		// both pins in edge mode latch once, ack clears, level follows pin
		u_dtc_cpu_model.wr(8'h88, 8'h05);
		pins.ext_irq1_pin_n = 1'b0;
		pins.ext_irq0_pin_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("irq1 edge", 8'h01, {7'h00, flags.ext_irq1_flag});
		chk("irq0 edge", 8'h01, {7'h00, flags.ext_irq0_flag});
		u_dtc_cpu_model.vec(4'h3);
		repeat (2) @(negedge ref_clk);
		chk("irq1 ack", 8'h00, {7'h00, flags.ext_irq1_flag});
		chk("irq0 ack", 8'h00, {7'h00, flags.ext_irq0_flag});
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		@(negedge ref_clk);
		chk("irq1 level", 8'h01, {7'h00, flags.ext_irq1_flag});
		pins.ext_irq1_pin_n = 1'b1;
		pins.ext_irq0_pin_n = 1'b1;
		// 13-bit wrap on the divided clock; one tick at most before stop
		u_dtc_cpu_model.wr(8'h89, 8'h00);
		u_dtc_cpu_model.wr(8'h8E, 8'h00);
		u_dtc_cpu_model.wr(8'h8A, 8'h1F);
		u_dtc_cpu_model.wr(8'h8C, 8'hFF);
		u_dtc_cpu_model.wr(8'h88, 8'h10);
		for (int k = 0; k < 14 && flags.timer0_overflow_flag !== 1'b1; k++)
			@(negedge ref_clk);
		chk("t0 13b", 8'h01, {7'h00, flags.timer0_overflow_flag});
		if (flags.timer0_overflow_flag !== 1'b1) give_verdict();
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		rchk(8'h8A, 8'h00);
		rchk(8'h8C, 8'h00);
		u_dtc_cpu_model.vec(4'h4);
		// timer1 reload: low byte refills, high byte untouched
		u_dtc_cpu_model.wr(8'h89, 8'h20);
		u_dtc_cpu_model.wr(8'h8E, 8'h10);
		u_dtc_cpu_model.wr(8'h8B, 8'hFE);
		u_dtc_cpu_model.wr(8'h8D, 8'h80);
		u_dtc_cpu_model.wr(8'h88, 8'h40);
		repeat (2) @(negedge ref_clk);
		chk("t1 flag", 8'h01, {7'h00, flags.timer1_overflow_flag});
		chk("t1 pulse", 8'h01, {7'h00, ovf1});
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		rchk(8'h8B, 8'h82);
		rchk(8'h8D, 8'h80);
		u_dtc_cpu_model.vec(4'h8);
		chk("t1 ack", 8'h00, {7'h00, flags.timer1_overflow_flag});
		// timer1 stopped mode holds even with its run bit set
		u_dtc_cpu_model.wr(8'h89, 8'h30);
		u_dtc_cpu_model.wr(8'h88, 8'h40);
		repeat (4) @(negedge ref_clk);
		rchk(8'h8B, 8'h82);
		// split mode: timer0 high byte, run by timer1 bit, sets timer1 flag
		u_dtc_cpu_model.wr(8'h88, 8'h00);
		u_dtc_cpu_model.wr(8'h89, 8'h03);
		u_dtc_cpu_model.wr(8'h8E, 8'h08);
		u_dtc_cpu_model.wr(8'h8C, 8'hFF);
		u_dtc_cpu_model.wr(8'h88, 8'h40);
		@(negedge ref_clk);
		chk("split flags", 8'h08, {4'h0, flags});
		give_verdict();
	end
endmodule
`default_nettype wire
